// >>> bench/power_stage_model.sv
// comparator and fault sense model at the far side of the pwm block
`default_nettype none

module power_stage_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // sensed conditions, slow adds one comparator delay
    input wire logic [7:0] limit_cond,
    input wire logic [7:0] fault_cond,
    input wire logic slow,
    // comparator outputs, active high
    output logic [7:0] current_limit_in,
    output logic [7:0] fault_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] s1_q;
    logic [15:0] s2_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= {limit_cond, fault_cond};
            s2_q <= s1_q;
        end
    end
    // a slow comparator trades response time for noise immunity
    assign {current_limit_in, fault_in} = slow ? s2_q : s1_q;
endmodule

`default_nettype wire

// >>> bench/pwm_aux_props.sv
// concurrent checks on the ports of the pwm auxiliary block
`default_nettype none

module pwm_aux_props
    import pwm_aux_pkg::*;
(
    // clock, reset and apb
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    input wire logic pready,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pslverr,
    // generator side
    input wire logic [NUM_GEN-1:0] high_side_in,
    input wire logic [NUM_GEN-1:0] current_limit_in,
    input wire logic [NUM_GEN-1:0] fault_in,
    input wire logic [NUM_GEN-1:0] high_side_output,
    input wire logic [NUM_GEN-1:0] current_limit_out,
    input wire logic [NUM_GEN-1:0] fault_out,
    input wire logic [NUM_GEN-1:0] fine_period_off,
    input wire logic [NUM_GEN-1:0] fine_duty_off
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready;

    a_err_unmapped: assert property (
        acc && paddr >= MAP_END |-> pslverr)
        else $error("no error on unmapped access");
    a_cap_read_only: assert property (acc && pwrite
        && paddr < MAP_END && paddr[3:2] == 2'b11 |-> pslverr)
        else $error("capture write accepted");
    a_delay_zero_bits: assert property (acc && !pwrite
        && paddr < MAP_END && paddr[3:2] == 2'b01
        |-> prdata[15:12] == 4'h0 && prdata[2:0] == 3'h0)
        else $error("delay unimplemented bits set");
    a_cap_low_zero: assert property (acc && !pwrite
        && paddr < MAP_END && paddr[3:2] == 2'b11 |-> prdata[2:0] == 3'h0)
        else $error("capture low bits set");
    a_period_off_bit: assert property (acc && pwrite
        && paddr == AUXILIARY_CONTROL_OFS |=> fine_period_off[0]
        == $past(pwdata[FINE_PERIOD_OFF_BIT]))
        else $error("fine period off not taken");
    a_off_on_write: assert property (
        $changed({fine_period_off, fine_duty_off}) |-> $past(acc && pwrite))
        else $error("fine off moved without write");
    a_limit_has_cause: assert property (current_limit_out[0]
        |-> $past(current_limit_in[0]))
        else $error("limit out without input");
    a_fault_has_cause: assert property (fault_out[0]
        |-> $past(fault_in[0]))
        else $error("fault out without input");
    a_chop_only_gates: assert property (high_side_output[0]
        |-> $past(high_side_in[0]))
        else $error("high side out without input");
endmodule

`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the pwm auxiliary block
`default_nettype none

module tb_top
    import pwm_aux_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [7:0] a; logic [15:0] r; logic e;} reg_row_t;
    typedef struct {logic [15:0] c, x; logic [7:0] h, l; logic o;} blk_row_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [DATA_W-1:0] pwdata = '0;
    logic pready, pslverr, er;
    logic [DATA_W-1:0] prdata, rd;
    logic [NUM_GEN-1:0] hs = '0;
    logic [NUM_GEN-1:0] ls = '0;
    logic [NUM_GEN-1:0] lc = '0;
    logic [NUM_GEN-1:0] fc = '0;
    logic slow = 1'b0;
    logic [NUM_GEN-1:0][TB_W-1:0] tbase = '0;
    logic [NUM_GEN-1:0] hso, lso, clo, fo, fpo, fdo, cli, fli;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int n;
    reg_row_t regs[5] = '{'{8'h00, 16'hfc3f, 1'b0}, '{8'h74, 16'h0ff8, 1'b0},
        '{8'h38, 16'hcf3f, 1'b0}, '{8'h1c, 16'h0, 1'b1}, '{8'h80, 16'h0, 1'b1}};
    blk_row_t blk[9] = '{'{16'h2, 16'h0, 8'h0, 8'h1, 1'b0},
        '{16'h2, 16'h0, 8'h0, 8'h0, 1'b1}, '{16'h1, 16'h0, 8'h0, 8'h0, 1'b0},
        '{16'h1, 16'h0, 8'h0, 8'h1, 1'b1}, '{16'h8, 16'h0, 8'h1, 8'h0, 1'b0},
        '{16'h20, 16'h200, 8'h2, 8'h0, 1'b0},
        '{16'h10, 16'h200, 8'h0, 8'h0, 1'b0},
        '{16'h20, 16'h900, 8'hff, 8'h0, 1'b1},
        '{16'h20, 16'h0, 8'hff, 8'h0, 1'b1}};

    initial begin
        forever #2 pclk = ~pclk;
    end

    pwm_aux_blanking #(.CHOP_HALF(2)) i_dut (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .pready, .prdata, .pslverr, .high_side_in(hs), .low_side_in(ls),
        .time_base(tbase), .current_limit_in(cli), .fault_in(fli),
        .high_side_output(hso), .low_side_output(lso),
        .current_limit_out(clo), .fault_out(fo),
        .fine_period_off(fpo), .fine_duty_off(fdo));

    power_stage_model i_stage (.pclk, .presetn, .limit_cond(lc),
        .fault_cond(fc), .slow, .current_limit_in(cli), .fault_in(fli));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one idle edge after each transfer keeps drives apart
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
        paddr <= a;
        pwrite <= wr;
        pwdata <= {16'h0, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // whole run is a few hundred cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (regs[i]) begin
            apb(1'b1, regs[i].a, 16'hffff);
            chk(32'(er), 32'(regs[i].e), "write error");
            apb(1'b0, regs[i].a, 16'h0);
            chk(rd, {16'h0, regs[i].r}, "readback");
        end
        chk(32'(fpo), 32'h8, "fine period off");
        chk(32'(fdo), 32'h8, "fine duty off");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 8'h38, 16'h0);
        chk(rd, 32'h0, "aux after reset");
        chk(32'(fpo), 32'h0, "fine off after reset");
        lc <= 8'h01;
        fc <= 8'h01;
        foreach (blk[i]) begin
            apb(1'b1, BLANKING_CONTROL_OFS, blk[i].c);
            apb(1'b1, AUXILIARY_CONTROL_OFS, blk[i].x);
            hs <= blk[i].h;
            ls <= blk[i].l;
            repeat (4) @(posedge pclk);
            chk(32'(clo[0]), 32'(blk[i].o), "limit out");
            chk(32'(fo[0]), 32'(blk[i].o), "fault out");
        end
        ls <= 8'h01;
        for (int k = 1; k <= 9; k++) begin
            apb(1'b1, AUXILIARY_CONTROL_OFS, 16'(k * 4 + 1));
            hs <= (k < 9) ? ~(8'h01 << (k - 1)) : 8'h00;
            repeat (3) @(posedge pclk);
            chk(32'(lso[0]), 32'(k == 9), "chopped low");
            hs <= (k < 9) ? (8'h01 << (k - 1)) : 8'h00;
            repeat (3) @(posedge pclk);
            chk(32'(lso[0]), 32'h1, "passed low");
        end
        apb(1'b1, AUXILIARY_CONTROL_OFS, 16'h000a);
        hs <= 8'h01;
        repeat (3) @(posedge pclk);
        chk(32'(hso[0]), 32'h0, "chopped high");
        hs <= 8'h03;
        repeat (3) @(posedge pclk);
        chk(32'(hso[0]), 32'h1, "passed high");
        apb(1'b1, AUXILIARY_CONTROL_OFS, 16'h0002);
        n = 0;
        repeat (8) begin
            @(posedge pclk);
            n += int'(hso[0]);
        end
        chk(32'(n), 32'h4, "chop clock highs");
        // capture used with pin resource mode clear
        apb(1'b1, AUXILIARY_CONTROL_OFS, 16'h0000);
        apb(1'b1, BLANKING_DELAY_OFS, 16'h0050);
        apb(1'b1, BLANKING_CONTROL_OFS, 16'h8400);
        hs <= 8'h00;
        lc <= 8'h00;
        fc <= 8'h00;
        slow <= 1'b1;
        tbase[0] <= 13'h0aaa;
        repeat (4) @(posedge pclk);
        hs <= 8'h01;
        lc <= 8'h01;
        repeat (8) @(posedge pclk);
        chk(32'(clo[0]), 32'h0, "limit in window");
        tbase[0] <= 13'h1555;
        repeat (24) @(posedge pclk);
        chk(32'(clo[0]), 32'h1, "limit after window");
        apb(1'b0, 8'h0c, 16'h0);
        chk(rd, 32'h0000aaa8, "capture");
        apb(1'b0, 8'h1c, 16'h0);
        chk(rd, 32'h0, "other capture");
        stop_test();
    end
endmodule

bind pwm_aux_blanking pwm_aux_props i_props (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .prdata, .pslverr, .high_side_in, .current_limit_in, .fault_in,
    .high_side_output, .current_limit_out, .fault_out, .fine_period_off,
    .fine_duty_off);

`default_nettype wire

// >>> pkg/blank_tmr_if.sv
// carrier between a generator slice and its leading-edge blanking timer
`default_nettype none

interface blank_tmr_if;
    import pwm_aux_pkg::*;
    logic start;
    logic [DLY_W-1:0] delay;
    logic tick;
    logic active;
    modport ctrl (output start, output delay, output tick, input active);
    modport timer (input start, input delay, input tick, output active);
endinterface

`default_nettype wire

// >>> pkg/pwm_aux_pkg.sv
// constants, register map and types for the pwm auxiliary blanking/chop block
`default_nettype none

package pwm_aux_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_GEN = 8;
    localparam int GEN_IDX_W = 3;
    localparam int TB_W = 13;
    localparam int DLY_W = 9;
    localparam int SEL_W = 4;
    localparam int REG_W = 16;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------------
    // register map: one 16 byte window per generator
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] BLANKING_CONTROL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] BLANKING_DELAY_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] AUXILIARY_CONTROL_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] TIME_BASE_CAPTURE_OFS = 8'h0c;
    localparam logic [ADDR_W-1:0] REG_OFS_MASK = 8'h0f;
    localparam logic [ADDR_W-1:0] MAP_END = 8'h80;
    localparam int GEN_LSB = 4;
    localparam logic [REG_W-1:0] REG_RESET = 16'h0000;

    // ------------------------------------------------------------------
    // blanking_control fields
    // ------------------------------------------------------------------
    localparam int HS_RISE_TRIG_BIT = 15;
    localparam int HS_FALL_TRIG_BIT = 14;
    localparam int LS_RISE_TRIG_BIT = 13;
    localparam int LS_FALL_TRIG_BIT = 12;
    localparam int FAULT_DELAY_ON_BIT = 11;
    localparam int LIMIT_DELAY_ON_BIT = 10;
    localparam int SRC_HIGH_BIT = 5;
    localparam int SRC_LOW_BIT = 4;
    localparam int HS_HIGH_BIT = 3;
    localparam int HS_LOW_BIT = 2;
    localparam int LS_HIGH_BIT = 1;
    localparam int LS_LOW_BIT = 0;
    localparam logic [REG_W-1:0] BLANKING_CONTROL_MASK = 16'hfc3f;

    // ------------------------------------------------------------------
    // blanking_delay, auxiliary_control and capture fields
    // ------------------------------------------------------------------
    localparam int DLY_LSB = 3;
    localparam logic [REG_W-1:0] BLANKING_DELAY_MASK = 16'h0ff8;
    localparam int FINE_PERIOD_OFF_BIT = 15;
    localparam int FINE_DUTY_OFF_BIT = 14;
    localparam int BLANK_SEL_LSB = 8;
    localparam int CHOP_SEL_LSB = 2;
    localparam int HS_CHOP_BIT = 1;
    localparam int LS_CHOP_BIT = 0;
    localparam logic [REG_W-1:0] AUXILIARY_CONTROL_MASK = 16'hcf3f;
    localparam int CAP_LSB = 3;

    // source selector codes
    localparam logic [SEL_W-1:0] SEL_INTERNAL = 4'h0;
    localparam logic [SEL_W-1:0] SEL_FIRST_GEN = 4'h1;
    localparam logic [SEL_W-1:0] SEL_LAST_GEN = 4'h8;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 4000;
    localparam int BLANK_STEP_PS = 8320;
    localparam int BLANK_STEP_MIN_CYCLES =
        (BLANK_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CHOP_HALF_CYCLES = 16;

    typedef enum logic {TMR_IDLE, TMR_COUNT} blank_tmr_state_t;

endpackage

`default_nettype wire

// >>> src/blank_timer.sv
// leading-edge blanking down-counter for one generator
`default_nettype none

module blank_timer
    import pwm_aux_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control side
    blank_tmr_if.timer bus
);

    blank_tmr_state_t state_q;
    logic [DLY_W-1:0] count_q;

    assign bus.active = (state_q == TMR_COUNT);

    // a new trigger reloads the count, so overlapping edges extend
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= TMR_IDLE;
            count_q <= '0;
        end else if (bus.start && bus.delay != '0) begin
            state_q <= TMR_COUNT;
            count_q <= bus.delay;
        end else begin
            case (state_q)
                TMR_IDLE: begin
                    count_q <= '0;
                end
                TMR_COUNT: begin
                    if (bus.tick) begin
                        count_q <= count_q - DLY_W'(1);
                        if (count_q == DLY_W'(1)) begin
                            state_q <= TMR_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= TMR_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> src/pwm_aux_blanking.sv
// eight-generator pwm blanking, chopping and time base capture with apb
//
// Chosen here: register access over APB and the register offsets.
`default_nettype none

// Notes on behaviour
// - low-side-high enable blanks limit and fault while low side high
// - low-side-low enable blanks limit and fault while low side low
// - blanking delay is nine bits at 11:3, one 8.32 ns step each
// - fine period off bit powers down fine period logic
// - fine duty off bit powers down fine duty logic
// - selected state-blank source blocks inputs per source-high/low enables
// - state-blank code 0 none, 1 to 8 generator high side, else reserved
// - chop source at bits 5:2 gates outputs that have chopping enabled
// - chop code 0 internal chop clock, 1 to 8 high sides, else reserved
// - high-side chop enable chops the high-side output
// - low-side chop enable chops the low-side output
// - limit leading edge latches time base into read-only bits 15:3
// - capture exists only for the primary high-side output
// - capture sees the limit input only after leading-edge blanking
// - captured value resolution is no finer than 8.32 ns
// - delay register bits 15:12 and 2:0 always read zero
// - high-side-high enable blanks limit and fault while high side high
module pwm_aux_blanking
    import pwm_aux_pkg::*;
#(
    parameter int CHOP_HALF = CHOP_HALF_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] pwdata,
    output logic pready,
    output logic [DATA_W-1:0] prdata,
    output logic pslverr,
    // raw generator outputs and time bases
    input wire logic [NUM_GEN-1:0] high_side_in,
    input wire logic [NUM_GEN-1:0] low_side_in,
    input wire logic [NUM_GEN-1:0][TB_W-1:0] time_base,
    // conditioned current-limit and fault inputs, active high
    input wire logic [NUM_GEN-1:0] current_limit_in,
    input wire logic [NUM_GEN-1:0] fault_in,
    // pins and blanked inputs towards the generators
    output logic [NUM_GEN-1:0] high_side_output,
    output logic [NUM_GEN-1:0] low_side_output,
    output logic [NUM_GEN-1:0] current_limit_out,
    output logic [NUM_GEN-1:0] fault_out,
    // power-down controls for the fine resolution logic
    output logic [NUM_GEN-1:0] fine_period_off,
    output logic [NUM_GEN-1:0] fine_duty_off
);

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    logic [NUM_GEN-1:0][REG_W-1:0] blanking_control_q;
    logic [NUM_GEN-1:0][REG_W-1:0] blanking_delay_q;
    logic [NUM_GEN-1:0][REG_W-1:0] auxiliary_control_q;
    logic [NUM_GEN-1:0][REG_W-1:0] time_base_capture_q;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic mapped;
    logic [ADDR_W-1:0] reg_ofs;
    logic [GEN_IDX_W-1:0] gen_idx;
    logic setup_phase;
    logic access_done;
    logic wr_ok;
    logic bad_access;
    logic [REG_W-1:0] rd_word;
    logic [DATA_W-1:0] prdata_q;
    logic pslverr_q;

    assign mapped = (paddr < MAP_END);
    assign reg_ofs = paddr & REG_OFS_MASK;
    assign gen_idx = paddr[GEN_LSB +: GEN_IDX_W];
    assign setup_phase = psel && !penable;
    // the slave never inserts wait states: every access phase completes
    assign pready = psel && penable;
    assign access_done = psel && penable && pready;
    // capture is read-only; a write to it is flagged, not stored
    assign bad_access = !mapped
        || (pwrite && reg_ofs == TIME_BASE_CAPTURE_OFS);
    assign wr_ok = access_done && pwrite && !bad_access;

    always_comb begin
        rd_word = REG_RESET;
        if (mapped) begin
            case (reg_ofs)
                BLANKING_CONTROL_OFS: begin
                    rd_word = blanking_control_q[gen_idx];
                end
                BLANKING_DELAY_OFS: begin
                    rd_word = blanking_delay_q[gen_idx];
                end
                AUXILIARY_CONTROL_OFS: begin
                    rd_word = auxiliary_control_q[gen_idx];
                end
                TIME_BASE_CAPTURE_OFS: begin
                    rd_word = time_base_capture_q[gen_idx];
                end
                default: begin
                    rd_word = REG_RESET;
                end
            endcase
        end
    end

    // read data is sampled in the setup cycle so it leaves a flip-flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
        end else if (setup_phase) begin
            prdata_q <= pwrite ? '0 : DATA_W'(rd_word);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            pslverr_q <= bad_access;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q && pready;

    // ------------------------------------------------------------------
    // shared rate enables
    // ------------------------------------------------------------------
    logic step_tick;
    logic chop_tick;
    logic chop_clk_q;

    // one blanking step of 8.32 ns on average, counted on 4 ns clocks
    step_divider #(
        .INC(CLK_PERIOD_PS),
        .LIMIT(BLANK_STEP_PS),
        .ACC_W(16)
    ) u_step_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(step_tick)
    );

    step_divider #(
        .INC(1),
        .LIMIT(CHOP_HALF),
        .ACC_W(16)
    ) u_chop_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(chop_tick)
    );

    // internal chop clock, square wave of two chop half periods
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chop_clk_q <= 1'b0;
        end else if (chop_tick) begin
            chop_clk_q <= !chop_clk_q;
        end
    end

    // ------------------------------------------------------------------
    // per-generator slices
    // ------------------------------------------------------------------
    for (genvar g = 0; g < NUM_GEN; g++) begin : gen_slice
        logic [REG_W-1:0] ctl;
        logic [REG_W-1:0] aux;
        logic [SEL_W-1:0] blank_sel;
        logic [SEL_W-1:0] chop_sel;
        logic [GEN_IDX_W-1:0] blank_idx;
        logic [GEN_IDX_W-1:0] chop_idx;
        logic blank_src_ok;
        logic blank_src;
        logic chop_sig;
        logic state_blank;
        logic hs_q;
        logic ls_q;
        logic edge_trig;
        logic limit_pass;
        logic fault_pass;
        logic sel_me;
        blank_tmr_if tmr ();

        assign ctl = blanking_control_q[g];
        assign aux = auxiliary_control_q[g];
        assign sel_me = (gen_idx == GEN_IDX_W'(g));

        // register writes, each generator owns its own copy
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                blanking_control_q[g] <= REG_RESET;
                blanking_delay_q[g] <= REG_RESET;
                auxiliary_control_q[g] <= REG_RESET;
            end else if (wr_ok && sel_me) begin
                if (reg_ofs == BLANKING_CONTROL_OFS) begin
                    blanking_control_q[g] <=
                        pwdata[REG_W-1:0] & BLANKING_CONTROL_MASK;
                end
                // unimplemented delay bits are masked to zero
                if (reg_ofs == BLANKING_DELAY_OFS) begin
                    blanking_delay_q[g] <=
                        pwdata[REG_W-1:0] & BLANKING_DELAY_MASK;
                end
                if (reg_ofs == AUXILIARY_CONTROL_OFS) begin
                    auxiliary_control_q[g] <=
                        pwdata[REG_W-1:0] & AUXILIARY_CONTROL_MASK;
                end
            end
        end

        // fine resolution power-down straight from the register
        assign fine_period_off[g] = aux[FINE_PERIOD_OFF_BIT];
        assign fine_duty_off[g] = aux[FINE_DUTY_OFF_BIT];

        // source selectors; reserved codes select nothing
        assign blank_sel = aux[BLANK_SEL_LSB +: SEL_W];
        assign chop_sel = aux[CHOP_SEL_LSB +: SEL_W];
        assign blank_idx = GEN_IDX_W'(blank_sel - SEL_FIRST_GEN);
        assign chop_idx = GEN_IDX_W'(chop_sel - SEL_FIRST_GEN);
        assign blank_src_ok = (blank_sel >= SEL_FIRST_GEN)
            && (blank_sel <= SEL_LAST_GEN);
        assign blank_src = blank_src_ok && high_side_in[blank_idx];

        // raw levels are used as sources so generators chopping each
        // other cannot form a combinational loop
        always_comb begin
            if (chop_sel == SEL_INTERNAL) begin
                chop_sig = chop_clk_q;
            end else if (chop_sel <= SEL_LAST_GEN) begin
                chop_sig = high_side_in[chop_idx];
            end else begin
                chop_sig = 1'b1;
            end
        end

        // level-based state blanking
        assign state_blank =
            (blank_src_ok && ctl[SRC_HIGH_BIT] && blank_src)
            || (blank_src_ok && ctl[SRC_LOW_BIT] && !blank_src)
            || (ctl[HS_HIGH_BIT] && high_side_in[g])
            || (ctl[HS_LOW_BIT] && !high_side_in[g])
            || (ctl[LS_HIGH_BIT] && low_side_in[g])
            || (ctl[LS_LOW_BIT] && !low_side_in[g]);

        // edge triggers for the leading-edge blanking timer
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hs_q <= 1'b0;
                ls_q <= 1'b0;
            end else begin
                hs_q <= high_side_in[g];
                ls_q <= low_side_in[g];
            end
        end

        assign edge_trig =
            (ctl[HS_RISE_TRIG_BIT] && high_side_in[g] && !hs_q)
            || (ctl[HS_FALL_TRIG_BIT] && !high_side_in[g] && hs_q)
            || (ctl[LS_RISE_TRIG_BIT] && low_side_in[g] && !ls_q)
            || (ctl[LS_FALL_TRIG_BIT] && !low_side_in[g] && ls_q);

        assign tmr.start = edge_trig;
        assign tmr.delay = blanking_delay_q[g][DLY_LSB +: DLY_W];
        assign tmr.tick = step_tick;

        blank_timer u_timer (
            .pclk(pclk),
            .presetn(presetn),
            .bus(tmr.timer)
        );

        // inputs pass only when neither state nor timed blanking holds
        assign limit_pass = current_limit_in[g] && !state_blank
            && !(ctl[LIMIT_DELAY_ON_BIT] && tmr.active);
        assign fault_pass = fault_in[g] && !state_blank
            && !(ctl[FAULT_DELAY_ON_BIT] && tmr.active);

        // outputs registered: one clock of latency on every path
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                high_side_output[g] <= 1'b0;
                low_side_output[g] <= 1'b0;
                current_limit_out[g] <= 1'b0;
                fault_out[g] <= 1'b0;
            end else begin
                high_side_output[g] <= high_side_in[g]
                    && (!aux[HS_CHOP_BIT] || chop_sig);
                low_side_output[g] <= low_side_in[g]
                    && (!aux[LS_CHOP_BIT] || chop_sig);
                current_limit_out[g] <= limit_pass;
                fault_out[g] <= fault_pass;
            end
        end

        // capture on the leading edge of the already blanked limit
        // signal, belonging to the high-side time base only; the time
        // base itself counts in steps no finer than 8.32 ns
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                time_base_capture_q[g] <= REG_RESET;
            end else if (limit_pass && !current_limit_out[g]) begin
                time_base_capture_q[g] <=
                    {time_base[g], {CAP_LSB{1'b0}}};
            end
        end
    end

endmodule

`default_nettype wire

// >>> src/step_divider.sv
// fractional divider giving one-cycle enable pulses at an average rate
`default_nettype none

module step_divider
    import pwm_aux_pkg::*;
#(
    parameter int unsigned INC = 1,
    parameter int unsigned LIMIT = 2,
    parameter int ACC_W = 16
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // enable pulse
    output logic tick
);

    logic [ACC_W-1:0] acc_q;
    logic [ACC_W-1:0] sum;

    // a fractional accumulator keeps the long-run average exact even
    // when the period is not a whole number of clocks
    assign sum = acc_q + ACC_W'(INC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q <= '0;
            tick <= 1'b0;
        end else if (sum >= ACC_W'(LIMIT)) begin
            acc_q <= sum - ACC_W'(LIMIT);
            tick <= 1'b1;
        end else begin
            acc_q <= sum;
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire
